// ---- logic/sirt_consts.svh ----
// Register offsets, field positions, reset values and scaling for the interrupt and trim block.
`ifndef SIRT_CONSTS_SVH
`define SIRT_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SIRT_OFS_PIN_CFG      8'h28
`define SIRT_OFS_SRC_ENABLE   8'h29
`define SIRT_OFS_PIN_ROUTING  8'h2a
`define SIRT_OFS_PRESS_TRIM   8'h2b
`define SIRT_OFS_TEMP_TRIM    8'h2c
`define SIRT_OFS_ALT_TRIM     8'h2d
`define SIRT_OFS_SRC_FLAGS    8'h12

// ****************************************************************
// Field positions in the pin configuration register
// ****************************************************************
`define SIRT_BIT_PIN_A_POLARITY     5
`define SIRT_BIT_PIN_A_DRIVE_STYLE  4
`define SIRT_BIT_PIN_B_POLARITY     1
`define SIRT_BIT_PIN_B_DRIVE_STYLE  0
`define SIRT_PIN_CFG_MASK           8'h33

// ****************************************************************
// Event bit positions, shared by enable, routing and flag registers
// ****************************************************************
`define SIRT_EVT_DATA_READY       7
`define SIRT_EVT_FIFO             6
`define SIRT_EVT_PRESS_WINDOW     5
`define SIRT_EVT_TEMP_WINDOW      4
`define SIRT_EVT_PRESS_THRESHOLD  3
`define SIRT_EVT_TEMP_THRESHOLD   2
`define SIRT_EVT_PRESS_CHANGE     1
`define SIRT_EVT_TEMP_CHANGE      0
`define SIRT_RAW_KEEP_MASK        8'h80

// ****************************************************************
// Reset values and trim scaling
// ****************************************************************
`define SIRT_RST_PIN_CFG      8'h00
`define SIRT_RST_SRC_ENABLE   8'h00
`define SIRT_RST_PIN_ROUTING  8'h00
`define SIRT_RST_TRIM         8'h00
`define SIRT_PRESS_TRIM_SHIFT 4
`define SIRT_ALT_TRIM_SHIFT   4

`endif

// ---- logic/sirt_irq_trim.sv ----
// Interrupt enable, routing and pin control with user offset trim of measurement results.
`timescale 1ns/1ps
`default_nettype none
`include "sirt_consts.svh"

module sirt_irq_trim
(
    input  wire logic                       sys_clk,      // System clock, 200 MHz.
    input  wire logic                       rst_n,        // Asynchronous reset, active low.
    input  wire sirt_pkg::sirt_reg_req_t    regReq,       // Register write and read request.
    output logic [7:0]                      regRdData,    // Read data, valid the cycle after rdEn.
    input  wire logic [7:0]                 eventFlags,   // Event source flags, same clock.
    input  wire logic                       rawMode,      // Raw output mode selected.
    input  wire sirt_pkg::sirt_meas_t       measIn,       // Untrimmed measurement results.
    input  wire logic                       measInValid,  // Pulse: measIn is new.
    output sirt_pkg::sirt_meas_t            measOut,      // Trimmed measurement results.
    output logic                            measOutValid, // Pulse: measOut is new.
    output sirt_pkg::sirt_pin_drive_t       irqPinA,      // Drive of interrupt pin A.
    output sirt_pkg::sirt_pin_drive_t       irqPinB       // Drive of interrupt pin B.
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] pinCfg;
    logic [7:0] srcEnable;
    logic [7:0] pinRouting;
    logic [7:0] pressTrim;
    logic [7:0] tempTrim;
    logic [7:0] altTrim;
    logic [7:0] next_pinCfg;
    logic [7:0] next_srcEnable;
    logic [7:0] next_pinRouting;
    logic [7:0] next_pressTrim;
    logic [7:0] next_tempTrim;
    logic [7:0] next_altTrim;
    logic [7:0] next_regRdData;
    logic [7:0] readMux;

    always_comb
    begin
        next_pinCfg     = pinCfg;
        next_srcEnable  = srcEnable;
        next_pinRouting = pinRouting;
        next_pressTrim  = pressTrim;
        next_tempTrim   = tempTrim;
        next_altTrim    = altTrim;
        if (regReq.wrEn)
        begin
            case (regReq.addr)
                `SIRT_OFS_PIN_CFG:     next_pinCfg     = regReq.wrData & `SIRT_PIN_CFG_MASK;
                `SIRT_OFS_SRC_ENABLE:  next_srcEnable  = regReq.wrData;
                `SIRT_OFS_PIN_ROUTING: next_pinRouting = regReq.wrData;
                `SIRT_OFS_PRESS_TRIM:  next_pressTrim  = regReq.wrData;
                `SIRT_OFS_TEMP_TRIM:   next_tempTrim   = regReq.wrData;
                `SIRT_OFS_ALT_TRIM:    next_altTrim    = regReq.wrData;
                default:               next_pinCfg     = pinCfg;
            endcase
        end
        case (regReq.addr)
            `SIRT_OFS_PIN_CFG:     readMux = pinCfg;
            `SIRT_OFS_SRC_ENABLE:  readMux = srcEnable;
            `SIRT_OFS_PIN_ROUTING: readMux = pinRouting;
            `SIRT_OFS_PRESS_TRIM:  readMux = pressTrim;
            `SIRT_OFS_TEMP_TRIM:   readMux = tempTrim;
            `SIRT_OFS_ALT_TRIM:    readMux = altTrim;
            // Live flags let the host find every active source behind one pin.
            `SIRT_OFS_SRC_FLAGS:   readMux = eventFlags;
            default:               readMux = 8'h00;
        endcase
        next_regRdData = regReq.rdEn ? readMux : regRdData;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinCfg     <= `SIRT_RST_PIN_CFG;
            srcEnable  <= `SIRT_RST_SRC_ENABLE;
            pinRouting <= `SIRT_RST_PIN_ROUTING;
            pressTrim  <= `SIRT_RST_TRIM;
            tempTrim   <= `SIRT_RST_TRIM;
            altTrim    <= `SIRT_RST_TRIM;
            regRdData  <= 8'h00;
        end
        else
        begin
            pinCfg     <= next_pinCfg;
            srcEnable  <= next_srcEnable;
            pinRouting <= next_pinRouting;
            pressTrim  <= next_pressTrim;
            tempTrim   <= next_tempTrim;
            altTrim    <= next_altTrim;
            regRdData  <= next_regRdData;
        end
    end

    // ****************************************************************
    // Event gating, routing and pin stages
    // ****************************************************************
    logic [7:0] gatedEvents;
    logic [7:0] routedA;
    logic [7:0] routedB;
    logic       pinAPolarity;
    logic       pinADriveStyle;
    logic       pinBPolarity;
    logic       pinBDriveStyle;

    assign pinAPolarity   = pinCfg[`SIRT_BIT_PIN_A_POLARITY];
    assign pinADriveStyle = pinCfg[`SIRT_BIT_PIN_A_DRIVE_STYLE];
    assign pinBPolarity   = pinCfg[`SIRT_BIT_PIN_B_POLARITY];
    assign pinBDriveStyle = pinCfg[`SIRT_BIT_PIN_B_DRIVE_STYLE];

    // Raw mode keeps data ready alive; alarms, deltas and FIFO events go quiet.
    assign gatedEvents = eventFlags & srcEnable
                       & (rawMode ? `SIRT_RAW_KEEP_MASK : 8'hff);
    assign routedA     = gatedEvents & pinRouting;
    assign routedB     = gatedEvents & ~pinRouting;

    // One register stage only, so any input change shows on the pin next edge.
    sirt_pin_driver pinADriver
    (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .polarity   (pinAPolarity),
        .driveStyle (pinADriveStyle),
        .assertReq  (|routedA),
        .drive      (irqPinA)
    );

    sirt_pin_driver pinBDriver
    (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .polarity   (pinBPolarity),
        .driveStyle (pinBDriveStyle),
        .assertReq  (|routedB),
        .drive      (irqPinB)
    );

    // ****************************************************************
    // Offset trim
    // ****************************************************************
    sirt_pkg::sirt_meas_t next_measOut;
    logic                 next_measOutValid;
    logic [19:0]          pressAdd;
    logic [11:0]          tempAdd;
    logic [19:0]          altAdd;

    // Pressure counts quarter pascals, so 4 Pa per step is a shift by four.
    assign pressAdd = {{8{pressTrim[7]}}, pressTrim, 4'h0};
    // Temperature counts sixteenths of a degree, one per trim step.
    assign tempAdd  = {{4{tempTrim[7]}}, tempTrim};
    // Altitude carries four fraction bits, so whole meters shift by four.
    assign altAdd   = {{8{altTrim[7]}}, altTrim, 4'h0};

    always_comb
    begin
        next_measOut      = measOut;
        next_measOutValid = measInValid;
        if (measInValid)
        begin
            if (rawMode)
            begin
                // Raw results carry no correction at all.
                next_measOut = measIn;
            end
            else
            begin
                next_measOut.pressure    = measIn.pressure + pressAdd;
                next_measOut.temperature = measIn.temperature + tempAdd;
                next_measOut.altitude    = measIn.altitude + altAdd;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            measOut      <= '0;
            measOutValid <= 1'b0;
        end
        else
        begin
            measOut      <= next_measOut;
            measOutValid <= next_measOutValid;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic justReset;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            justReset <= 1'b1;
        end
        else
        begin
            justReset <= 1'b0;
        end
    end

    function automatic logic pinActive(sirt_pkg::sirt_pin_drive_t d, logic pol);
        logic lvl;
        lvl = d.oe ? d.out : 1'b1;
        return lvl == pol;
    endfunction

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    pin_a_level_a: assert property (
        ##1 pinActive(irqPinA, $past(pinAPolarity)) == |$past(routedA))
        else $error("Pin A level does not follow its routed events and polarity.");
    pin_a_style_a: assert property (
        $past(pinADriveStyle)
        |-> (irqPinA.oe == 1'b0 || irqPinA.out == 1'b0) && !irqPinA.pullupEn)
        else $error("Pin A drives high in open drain mode.");
    pin_a_pushpull_a: assert property (
        !pinADriveStyle ##1 1'b1 |-> irqPinA.oe && irqPinA.pullupEn)
        else $error("Pin A is not driven in push-pull mode.");
    pin_b_level_a: assert property (
        ##1 pinActive(irqPinB, $past(pinBPolarity)) == |$past(routedB))
        else $error("Pin B level does not follow its routed events and polarity.");
    pin_b_style_a: assert property (
        $past(pinBDriveStyle)
        |-> (irqPinB.oe == 1'b0 || irqPinB.out == 1'b0) && !irqPinB.pullupEn)
        else $error("Pin B drives high in open drain mode.");
    disabled_quiet_a: assert property (
        (eventFlags & srcEnable) == 8'h00
        |=> !pinActive(irqPinA, $past(pinAPolarity))
            && !pinActive(irqPinB, $past(pinBPolarity)))
        else $error("A pin asserts with no enabled event.");
    enable_reset_a: assert property (
        justReset |-> srcEnable == 8'h00)
        else $error("Enables are not clear after reset.");
    route_to_a_a: assert property (
        !rawMode && (eventFlags & srcEnable & pinRouting) != 8'h00
        |=> pinActive(irqPinA, $past(pinAPolarity)))
        else $error("An event routed to pin A does not assert it.");
    route_to_b_a: assert property (
        !rawMode && (eventFlags & srcEnable & ~pinRouting) != 8'h00
        |=> pinActive(irqPinB, $past(pinBPolarity)))
        else $error("An event routed to pin B does not assert it.");
    trim_reset_a: assert property (
        justReset |-> pressTrim == 8'h00 && tempTrim == 8'h00 && altTrim == 8'h00)
        else $error("Trim registers are not clear after reset.");
    press_trim_a: assert property (
        measInValid && !rawMode
        |=> measOutValid && measOut.pressure ==
            20'($past(measIn.pressure) + 20'($signed($past(pressTrim)) * 16)))
        else $error("Pressure trim is not applied at 4 Pa per step.");
    temp_trim_a: assert property (
        measInValid && !rawMode
        |=> measOut.temperature ==
            12'($past(measIn.temperature) + 12'($signed($past(tempTrim)))))
        else $error("Temperature trim is not applied.");
    alt_trim_a: assert property (
        measInValid && !rawMode
        |=> measOut.altitude ==
            20'($past(measIn.altitude) + 20'($signed($past(altTrim)) * 16)))
        else $error("Altitude trim is not applied in whole meters.");
    raw_quiet_a: assert property (
        rawMode && !(eventFlags[`SIRT_EVT_DATA_READY] && srcEnable[`SIRT_EVT_DATA_READY])
        |=> !pinActive(irqPinA, $past(pinAPolarity))
            && !pinActive(irqPinB, $past(pinBPolarity)))
        else $error("A suppressed source passes in raw mode.");
    // Polarity must hold over both edges, or the pin shows the old setting for a cycle.
    pin_follow_a: assert property (
        $changed(|routedA) && $stable(pinAPolarity) ##1 $stable(pinAPolarity)
        |-> $changed(pinActive(irqPinA, pinAPolarity)))
        else $error("Pin A does not follow a change within one clock.");

    both_pins_c: cover property (pinActive(irqPinA, $past(pinAPolarity))
                                 && pinActive(irqPinB, $past(pinBPolarity)));
    open_drain_c: cover property (pinADriveStyle && pinAPolarity && |routedA);
    raw_drdy_c: cover property (rawMode && gatedEvents[`SIRT_EVT_DATA_READY]);
    neg_trim_c: cover property (measInValid && pressTrim[7] && altTrim[7]);

endmodule // sirt_irq_trim

`default_nettype wire

// ---- logic/sirt_pin_driver.sv ----
// Output stage of one interrupt pin: polarity and drive style applied to the combined request.
`timescale 1ns/1ps
`default_nettype none

module sirt_pin_driver
(
    input  wire logic                 sys_clk,     // System clock.
    input  wire logic                 rst_n,       // Asynchronous reset, active low.
    input  wire logic                 polarity,    // 1 selects active high.
    input  wire logic                 driveStyle,  // 1 selects open drain.
    input  wire logic                 assertReq,   // Combined request for this pin.
    output var  sirt_pkg::sirt_pin_drive_t drive   // Registered pin drive.
);

    sirt_pkg::sirt_pin_drive_t next_drive;
    logic                      level;

    always_comb
    begin
        level = assertReq ~^ polarity;
        next_drive.pullupEn = ~driveStyle;
        if (driveStyle)
        begin
            // An open drain pin may only pull low; the high level is left to the line.
            next_drive.out = 1'b0;
            next_drive.oe  = ~level;
        end
        else
        begin
            next_drive.out = level;
            next_drive.oe  = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Idle push-pull, active low: the pin rests high.
            drive <= '{out: 1'b1, oe: 1'b1, pullupEn: 1'b1};
        end
        else
        begin
            drive <= next_drive;
        end
    end

endmodule // sirt_pin_driver

`default_nettype wire

// ---- logic/sirt_pkg.sv ----
// Types shared by the interrupt routing and offset trim block.
`default_nettype none

package sirt_pkg;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } sirt_reg_req_t;

    typedef struct packed {
        logic [19:0] pressure;
        logic [11:0] temperature;
        logic [19:0] altitude;
    } sirt_meas_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pullupEn;
    } sirt_pin_drive_t;

endpackage

`default_nettype wire

// ---- tb/sirt_host_model.sv ----
// Host-side model of the two interrupt lines as the host sees them on the board.
`timescale 1ns/1ps
`default_nettype none

module sirt_host_model
(
    input  wire sirt_pkg::sirt_pin_drive_t pinA,   // Drive of interrupt pin A.
    input  wire sirt_pkg::sirt_pin_drive_t pinB,   // Drive of interrupt pin B.
    output logic                           levelA, // Wire level of pin A.
    output logic                           levelB  // Wire level of pin B.
);
    // A released line floats to the board pull-up, so an idle active-low open drain line reads high.
    assign levelA = pinA.oe ? pinA.out : 1'b1;
    assign levelB = pinB.oe ? pinB.out : 1'b1;
endmodule // sirt_host_model

`default_nettype wire

// ---- tb/test_sensor_irq_routing_and_offset_trim.sv ----
// Self-checking testbench of the interrupt routing and offset trim block.
`timescale 1ns/1ps
`default_nettype none
`include "sirt_consts.svh"

module test_sensor_irq_routing_and_offset_trim;
    logic                      sys_clk;
    logic                      rst_n;
    sirt_pkg::sirt_reg_req_t   regReq;
    logic [7:0]                regRdData;
    logic [7:0]                eventFlags;
    logic                      rawMode;
    sirt_pkg::sirt_meas_t      measIn;
    logic                      measInValid;
    sirt_pkg::sirt_meas_t      measOut;
    logic                      measOutValid;
    sirt_pkg::sirt_pin_drive_t irqPinA;
    sirt_pkg::sirt_pin_drive_t irqPinB;
    logic                      levelA;
    logic                      levelB;
    int                        n_mismatch;
    int                        n_compared;

    sirt_irq_trim i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
        .regRdData(regRdData), .eventFlags(eventFlags), .rawMode(rawMode),
        .measIn(measIn), .measInValid(measInValid), .measOut(measOut),
        .measOutValid(measOutValid), .irqPinA(irqPinA), .irqPinB(irqPinB));

    sirt_host_model i_host (.pinA(irqPinA), .pinB(irqPinB), .levelA(levelA), .levelB(levelB));

    // ****************************************************************
    // Access and comparison tasks
    // ****************************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(negedge sys_clk);
        regReq.wrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(negedge sys_clk);
        regReq.rdEn = 1'b0;
        check(regRdData, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // The host sees a level, so the level check is on the wire; pull-up and open drain are checked on the drive bits.
    task automatic pinChk(input logic actA, input logic actB, input logic [7:0] cfg);
        check(levelA, cfg[`SIRT_BIT_PIN_A_POLARITY] ? actA : !actA);
        check(levelB, cfg[`SIRT_BIT_PIN_B_POLARITY] ? actB : !actB);
        check(irqPinA.pullupEn, !cfg[`SIRT_BIT_PIN_A_DRIVE_STYLE]);
        check(irqPinB.pullupEn, !cfg[`SIRT_BIT_PIN_B_DRIVE_STYLE]);
        check(irqPinA.oe & irqPinA.out & cfg[`SIRT_BIT_PIN_A_DRIVE_STYLE], 1'b0);
        check(irqPinB.oe & irqPinB.out & cfg[`SIRT_BIT_PIN_B_DRIVE_STYLE], 1'b0);
    endtask

    task automatic meas(input sirt_pkg::sirt_meas_t m, input sirt_pkg::sirt_meas_t exp);
        @(negedge sys_clk);
        measIn = m;
        measInValid = 1'b1;
        @(negedge sys_clk);
        measInValid = 1'b0;
        check(measOutValid, 1'b1);
        check(measOut, exp);
        @(negedge sys_clk);
        check(measOutValid, 1'b0);
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence
    // ****************************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(5 * 20000);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        logic [7:0] r;
        logic [7:0] cfg;
        logic [7:0] f;
        logic [7:0] flagList [5];
        sirt_pkg::sirt_meas_t m;
        n_mismatch = 0;
        n_compared = 0;
        rst_n = 1'b0;
        regReq = '0;
        eventFlags = 8'hff;
        rawMode = 1'b0;
        measIn = '0;
        measInValid = 1'b0;
        flagList = '{8'h0c, 8'h04, 8'h00, 8'hf0, 8'h81};
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        settle(1);
        pinChk(1'b0, 1'b0, 8'h00);
        for (int a = 8'h28; a <= 8'h2d; a++)
            rd(8'(a), 8'h00);
        rd(8'h30, 8'h00);
        wr(`SIRT_OFS_PIN_CFG, 8'hff);
        rd(`SIRT_OFS_PIN_CFG, `SIRT_PIN_CFG_MASK);
        wr(`SIRT_OFS_PIN_CFG, 8'h00);
        $display("test of reset values done");

        // One event at a time, alternately routed to each pin, all flags raised.
        for (int i = 0; i < 8; i++)
        begin
            r = 8'h01 << i;
            wr(`SIRT_OFS_PIN_ROUTING, (i % 2 == 1) ? r : 8'h00);
            wr(`SIRT_OFS_SRC_ENABLE, r);
            rd(`SIRT_OFS_SRC_ENABLE, r);
            settle(1);
            pinChk(i % 2 == 1, i % 2 == 0, 8'h00);
            eventFlags = ~r;
            settle(1);
            pinChk(1'b0, 1'b0, 8'h00);
            eventFlags = 8'hff;
        end
        $display("test of enable and routing done");

        wr(`SIRT_OFS_SRC_ENABLE, 8'h03);
        wr(`SIRT_OFS_PIN_ROUTING, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            cfg = {2'b00, 2'(k), 2'b00, ~2'(k)};
            wr(`SIRT_OFS_PIN_CFG, cfg);
            eventFlags = 8'h02;
            settle(2);
            pinChk(1'b1, 1'b0, cfg);
            eventFlags = 8'h01;
            settle(1);
            pinChk(1'b0, 1'b1, cfg);
        end
        $display("test of polarity and drive style done");

        wr(`SIRT_OFS_PIN_CFG, 8'h00);
        wr(`SIRT_OFS_SRC_ENABLE, 8'hff);
        wr(`SIRT_OFS_PIN_ROUTING, 8'h0f);
        for (int raw = 0; raw < 2; raw++)
        begin
            rawMode = 1'(raw);
            foreach (flagList[j])
            begin
                eventFlags = flagList[j];
                f = flagList[j] & ((raw == 1) ? `SIRT_RAW_KEEP_MASK : 8'hff);
                settle(2);
                pinChk(|f[3:0], |f[7:4], 8'h00);
                rd(`SIRT_OFS_SRC_FLAGS, flagList[j]);
            end
        end
        rawMode = 1'b0;
        $display("test of combining and raw mode done");

        wr(`SIRT_OFS_PRESS_TRIM, 8'h80);
        wr(`SIRT_OFS_TEMP_TRIM, 8'h7f);
        wr(`SIRT_OFS_ALT_TRIM, 8'hff);
        rd(`SIRT_OFS_PRESS_TRIM, 8'h80);
        rd(`SIRT_OFS_TEMP_TRIM, 8'h7f);
        rd(`SIRT_OFS_ALT_TRIM, 8'hff);
        m = '{pressure: 20'h00010, temperature: 12'h005, altitude: 20'h00000};
        // Expected sums: -128 x 16 quarter Pa, +127 sixteenths, -1 m in Q16.4.
        meas(m, '{pressure: 20'hff810, temperature: 12'h084, altitude: 20'hffff0});
        rawMode = 1'b1;
        meas(m, m);
        rawMode = 1'b0;
        $display("test of offset trim done");

        // A reset in mid-run must clear what software wrote, with events still raised.
        @(negedge sys_clk);
        rst_n = 1'b0;
        settle(2);
        rst_n = 1'b1;
        settle(1);
        pinChk(1'b0, 1'b0, 8'h00);
        rd(`SIRT_OFS_SRC_ENABLE, 8'h00);
        rd(`SIRT_OFS_PIN_ROUTING, 8'h00);
        rd(`SIRT_OFS_PRESS_TRIM, 8'h00);
        rd(`SIRT_OFS_TEMP_TRIM, 8'h00);
        rd(`SIRT_OFS_ALT_TRIM, 8'h00);
        $display("test of reset in mid-run done");
        finish_test();
    end
endmodule // test_sensor_irq_routing_and_offset_trim

`default_nettype wire
